// ### design/self_test_ctrl.v
// reset strap decode, built-in self test sequencer and float test mode
`timescale 1ns/1ps
`include "self_test_map_map.vh"

module self_test_ctrl #(
  parameter BIST_CYCLES = `BIST_CLOCKS,
  parameter CNT_W = 20,
  parameter UROM_AW = 8,
  parameter PLA_IW = 6,
  parameter NUM_ARRAYS = 4,
  parameter ARRAY_AW = 4
)(
  input wire clk,
  input wire reset_n,
  input wire sys_reset,
  input wire address_hold_strap,
  input wire cache_flush_n,
  input wire external_snoop_strobe_n,
  input wire fan_too_slow,
  input wire stuck_fault_inject,
  input wire core_bus_request,
  input wire snoop_tag_hit,
  input wire fan_event_clear,
  output wire bus_cycle_start,
  output wire pin_drive_enable,
  output wire modified_hit_indication_n,
  output wire self_test_busy,
  output wire self_test_done,
  output wire float_mode,
  output wire core_running,
  output wire fan_slow_event,
  output wire [31:0] accumulator_result_register
);

  localparam ST_RESET = 8'h01;
  localparam ST_NORMAL = 8'h02;
  localparam ST_UROM = 8'h04;
  localparam ST_PLA = 8'h08;
  localparam ST_ARRAY = 8'h10;
  localparam ST_CONST = 8'h20;
  localparam ST_WAIT = 8'h40;
  localparam ST_FLOAT = 8'h80;
  localparam [31:0] BIST_LAST_FULL = BIST_CYCLES - 1;
  localparam [CNT_W-1:0] BIST_LAST = BIST_LAST_FULL[CNT_W-1:0];

  // =====================================================================
  // pin synchronisers
  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  wire [5:0] pin_raw = {sys_reset, address_hold_strap, cache_flush_n, external_snoop_strobe_n,
    fan_too_slow, stuck_fault_inject};

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_r <= `PIN_SYNC_INIT;
      pin_s2_r <= `PIN_SYNC_INIT;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire rst_s = pin_s2_r[5];
  wire strap_hold_s = pin_s2_r[4];
  wire flush_n_s = pin_s2_r[3];
  wire snoop_n_s = pin_s2_r[2];
  wire fan_s = pin_s2_r[1];
  wire fault_s = pin_s2_r[0];

  // =====================================================================
  // strap capture on the clock before reset falls
  reg rst_prev_r;
  reg strap_hold_prev_r;
  reg flush_n_prev_r;
  wire rst_fall = rst_prev_r & ~rst_s;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_prev_r <= 1'b1;
      strap_hold_prev_r <= 1'b0;
      flush_n_prev_r <= 1'b1;
    end
    else
    begin
      rst_prev_r <= rst_s;
      strap_hold_prev_r <= strap_hold_s;
      flush_n_prev_r <= flush_n_s;
    end
  end

  // =====================================================================
  // main sequencer
  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [CNT_W-1:0] bist_cnt_r;
  reg [UROM_AW-1:0] urom_addr_r;
  reg [PLA_IW-1:0] pla_in_r;
  reg [1:0] const_idx_r;
  reg [15:0] const_sum_r;
  reg arr_start_r;
  reg [6:0] fail_r;
  wire [NUM_ARRAYS-1:0] arr_finished;
  wire [NUM_ARRAYS-1:0] arr_fail;
  wire arrays_done = (&arr_finished) & ~arr_start_r;

  always @*
  begin
    state_nxt = state_r;
    if (rst_s)
      state_nxt = ST_RESET;
    else
    begin
      case (state_r)
        ST_RESET:
        begin
          if (rst_fall && !flush_n_prev_r)
            state_nxt = ST_FLOAT;
          else if (rst_fall && strap_hold_prev_r)
            state_nxt = ST_UROM;
          else if (rst_fall)
            state_nxt = ST_NORMAL;
        end
        ST_UROM:
          if (&urom_addr_r)
            state_nxt = ST_PLA;
        ST_PLA:
          if (&pla_in_r)
            state_nxt = ST_ARRAY;
        ST_ARRAY:
          if (arrays_done)
            state_nxt = ST_CONST;
        ST_CONST:
          if (&const_idx_r)
            state_nxt = ST_WAIT;
        ST_WAIT:
          if (bist_cnt_r >= BIST_LAST)
            state_nxt = ST_NORMAL;
        ST_FLOAT, ST_NORMAL:
          state_nxt = state_r;
        default:
          state_nxt = ST_RESET;
      endcase
    end
  end

  // =====================================================================
  // microcode ROM and PLA models
  function urom_bad;
    input [UROM_AW-1:0] a;
    reg [UROM_AW-1:0] data;
    reg par;
    begin
      data = a ^ {a[0], a[UROM_AW-1:1]};
      par = ^data;
      urom_bad = ^{data, par};
    end
  endfunction

  function pla_bad;
    input [PLA_IW-1:0] x;
    reg t;
    reg t_n;
    begin
      t = (x[0] & x[1]) | (x[2] & ~x[3]) | (x[PLA_IW-1] & x[4]);
      t_n = ~((x[0] & x[1]) | (x[2] & ~x[3]) | (x[PLA_IW-1] & x[4]));
      pla_bad = (t == t_n);
    end
  endfunction

  function [15:0] const_rom;
    input [1:0] i;
    begin
      case (i)
        2'h0: const_rom = `CONST_ROM_0;
        2'h1: const_rom = `CONST_ROM_1;
        2'h2: const_rom = `CONST_ROM_2;
        default: const_rom = `CONST_ROM_3;
      endcase
    end
  endfunction

  wire [15:0] const_sum_nxt = const_sum_r + const_rom(const_idx_r);

  // =====================================================================
  // test counters and failure accumulation
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_RESET;
      bist_cnt_r <= {CNT_W{1'b0}};
      urom_addr_r <= {UROM_AW{1'b0}};
      pla_in_r <= {PLA_IW{1'b0}};
      const_idx_r <= 2'h0;
      const_sum_r <= 16'h0000;
      arr_start_r <= 1'b0;
      fail_r <= 7'h00;
    end
    else
    begin
      state_r <= state_nxt;
      arr_start_r <= (state_r == ST_PLA) && (state_nxt == ST_ARRAY);
      if (rst_fall)
      begin
        bist_cnt_r <= {CNT_W{1'b0}};
        urom_addr_r <= {UROM_AW{1'b0}};
        pla_in_r <= {PLA_IW{1'b0}};
        const_idx_r <= 2'h0;
        const_sum_r <= 16'h0000;
        fail_r <= 7'h00;
      end
      else
      begin
        if (state_r == ST_UROM || state_r == ST_PLA || state_r == ST_ARRAY ||
            state_r == ST_CONST || state_r == ST_WAIT)
        begin
          bist_cnt_r <= bist_cnt_r + 1'b1;
        end
        if (state_r == ST_UROM)
        begin
          urom_addr_r <= urom_addr_r + 1'b1;
          if (urom_bad(urom_addr_r))
          begin
            fail_r[`RES_UROM_BIT] <= 1'b1;
          end
        end
        if (state_r == ST_PLA)
        begin
          pla_in_r <= pla_in_r + 1'b1;
          if (pla_bad(pla_in_r))
          begin
            fail_r[`RES_PLA_BIT] <= 1'b1;
          end
        end
        if (state_r == ST_ARRAY && arrays_done)
        begin
          fail_r[`RES_ARRAY_LSB +: NUM_ARRAYS] <= arr_fail;
        end
        if (state_r == ST_CONST)
        begin
          const_idx_r <= const_idx_r + 1'b1;
          const_sum_r <= const_sum_nxt;
          if ((&const_idx_r) && const_sum_nxt != `CONST_SUM_EXPECT)
          begin
            fail_r[`RES_CONST_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  // =====================================================================
  // array testers, one per cache, TLB and branch target array
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ARRAYS; gi = gi + 1)
    begin : g_arr
      array_march #(
        .ADDR_W(ARRAY_AW),
        .DATA_W(8),
        .PATTERN(`ARRAY_PATTERN)
      ) u_march (
        .clk(clk),
        .reset_n(reset_n),
        .start(arr_start_r),
        .fault_inject(fault_s),
        .finished_r(arr_finished[gi]),
        .fail_r(arr_fail[gi])
      );
    end
  endgenerate

  // =====================================================================
  // registered outputs
  reg bus_cycle_start_r;
  reg pin_drive_enable_r;
  reg mod_hit_n_r;
  reg busy_r;
  reg done_r;
  reg float_r;
  reg running_r;
  reg fan_event_r;
  reg [31:0] result_r;
  wire testing_nxt = (state_nxt == ST_UROM) || (state_nxt == ST_PLA) || (state_nxt == ST_ARRAY) ||
    (state_nxt == ST_CONST) || (state_nxt == ST_WAIT);
  wire normal_nxt = (state_nxt == ST_NORMAL);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_cycle_start_r <= 1'b0;
      pin_drive_enable_r <= 1'b1;
      mod_hit_n_r <= 1'b1;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      float_r <= 1'b0;
      running_r <= 1'b0;
      fan_event_r <= 1'b0;
      result_r <= `RESULT_PASS;
    end
    else
    begin
      bus_cycle_start_r <= core_bus_request & normal_nxt;
      pin_drive_enable_r <= (state_nxt != ST_FLOAT);
      float_r <= (state_nxt == ST_FLOAT);
      mod_hit_n_r <= ~(normal_nxt & ~snoop_n_s & snoop_tag_hit);
      busy_r <= testing_nxt;
      running_r <= normal_nxt;
      done_r <= (state_r == ST_WAIT) && normal_nxt;
      if (rst_fall)
        result_r <= `RESULT_PASS;
      else if ((state_r == ST_WAIT) && normal_nxt)
        result_r <= {25'h0000000, fail_r};
      if (state_r != ST_FLOAT && fan_s)
        fan_event_r <= 1'b1;
      else if (fan_event_clear)
        fan_event_r <= 1'b0;
    end
  end

  assign bus_cycle_start = bus_cycle_start_r;
  assign pin_drive_enable = pin_drive_enable_r;
  assign modified_hit_indication_n = mod_hit_n_r;
  assign self_test_busy = busy_r;
  assign self_test_done = done_r;
  assign float_mode = float_r;
  assign core_running = running_r;
  assign fan_slow_event = fan_event_r;
  assign accumulator_result_register = result_r;

endmodule

// ### shared/self_test_map_map.vh
// constants for the reset strap, self test and float mode block
`ifndef SELF_TEST_MAP_MAP_VH
`define SELF_TEST_MAP_MAP_VH

// =====================================================================
// result word layout
`define RES_UROM_BIT 0
`define RES_PLA_BIT 1
`define RES_ARRAY_LSB 2
`define RES_CONST_BIT 6
`define RESULT_PASS 32'h00000000

// =====================================================================
// timing counts
`define BIST_CLOCKS 524288
`define STRAP_HOLD_CLOCKS 2
`define FLOAT_LIMIT_CLOCKS 10

// =====================================================================
// pin synchroniser reset values, reset asserted and the others at their idle levels: {reset, hold strap, flush_n, snoop_n, fan, fault}
`define PIN_SYNC_INIT 6'h2C

// =====================================================================
// constant ROM contents and expected sum
`define CONST_ROM_0 16'h1111
`define CONST_ROM_1 16'h2222
`define CONST_ROM_2 16'h3333
`define CONST_ROM_3 16'h4444
`define CONST_SUM_EXPECT 16'hAAAA

// =====================================================================
// array test pattern
`define ARRAY_PATTERN 8'h5A

`endif

// ### design/array_march.v
// two-pass pattern and complement test of one on-chip array
`timescale 1ns/1ps
`include "self_test_map_map.vh"

module array_march #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8,
  parameter [DATA_W-1:0] PATTERN = `ARRAY_PATTERN
)(
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire fault_inject,
  output reg finished_r,
  output reg fail_r
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  reg [ADDR_W-1:0] addr_r;
  reg pass_r;
  reg reading_r;
  reg running_r;
  wire [DATA_W-1:0] pat = pass_r ? ~PATTERN : PATTERN;
  wire [DATA_W-1:0] rd_data = mem[addr_r] ^ {{(DATA_W-1){1'b0}}, fault_inject};
  wire last_addr = &addr_r;

  // =====================================================================
  // array storage
  always @(posedge clk)
  begin
    if (running_r && !reading_r)
    begin
      mem[addr_r] <= pat;
    end
  end

  // =====================================================================
  // pass sequencing and compare
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_r <= {ADDR_W{1'b0}};
      pass_r <= 1'b0;
      reading_r <= 1'b0;
      running_r <= 1'b0;
      finished_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else if (start)
    begin
      addr_r <= {ADDR_W{1'b0}};
      pass_r <= 1'b0;
      reading_r <= 1'b0;
      running_r <= 1'b1;
      finished_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else if (running_r)
    begin
      addr_r <= addr_r + 1'b1;
      if (reading_r && rd_data != pat)
      begin
        fail_r <= 1'b1;
      end
      if (last_addr)
      begin
        reading_r <= ~reading_r;
        if (reading_r)
        begin
          if (pass_r)
          begin
            running_r <= 1'b0;
            finished_r <= 1'b1;
          end
          pass_r <= 1'b1;
        end
      end
    end
  end

endmodule

// ### testbench/board_reset_model.sv
// board reset pin and strap driver model
`timescale 1ns/1ps
module board_reset_model (
  input wire clk,
  output reg sys_reset,
  output reg address_hold_strap,
  output reg cache_flush_n
);
  // released straps rest at their pull levels
  initial
  begin
    sys_reset = 1'b0;
    address_hold_strap = 1'b0;
    cache_flush_n = 1'b1;
  end
  // ==========
  // reset pulse with straps held around the falling edge
  task pulse_reset(input logic self_test, input logic float_req);
    begin
      @(negedge clk);
      sys_reset = 1'b1;
      repeat (3) @(negedge clk);
      address_hold_strap = self_test;
      cache_flush_n = !float_req;
      repeat (3) @(negedge clk);
      sys_reset = 1'b0;
      repeat (2) @(negedge clk);
      address_hold_strap = 1'b0;
      cache_flush_n = 1'b1;
    end
  endtask
endmodule

// ### testbench/self_test_checker.sv
// port checks for strap decode, self test and float mode
`timescale 1ns/1ps
module self_test_checker #(
  parameter BIST_CYCLES = 524288
)(
  input wire clk,
  input wire reset_n,
  input wire sys_reset,
  input wire address_hold_strap,
  input wire cache_flush_n,
  input wire fan_too_slow,
  input wire fan_event_clear,
  input wire bus_cycle_start,
  input wire pin_drive_enable,
  input wire modified_hit_indication_n,
  input wire self_test_busy,
  input wire self_test_done,
  input wire float_mode,
  input wire core_running,
  input wire fan_slow_event,
  input wire [31:0] accumulator_result_register
);
  // ==========
  // length of the current busy stretch
  reg [31:0] busy_cnt_r;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_cnt_r <= 32'h0;
    else if (self_test_busy)
      busy_cnt_r <= busy_cnt_r + 32'h1;
    else
      busy_cnt_r <= 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // reset falls, by strap choice
  sequence s_fall_test;
    $fell(sys_reset) && address_hold_strap && cache_flush_n;
  endsequence
  sequence s_fall_plain;
    $fell(sys_reset) && !address_hold_strap && cache_flush_n;
  endsequence
  sequence s_fall_float;
    $fell(sys_reset) && !cache_flush_n;
  endsequence
  property p_test_start;
    s_fall_test |-> ##[1:4] self_test_busy;
  endproperty
  a_test_start: assert property (p_test_start) else $error("self test not started");
  property p_plain;
    s_fall_plain |-> ##[1:4] (core_running && !self_test_busy && !float_mode && accumulator_result_register == 0);
  endproperty
  a_plain: assert property (p_plain) else $error("plain reset wrong");
  property p_float_fast;
    s_fall_float |-> ##[1:10] (float_mode && !pin_drive_enable);
  endproperty
  a_float_fast: assert property (p_float_fast) else $error("float too late");
  property p_no_bus;
    self_test_busy |-> !bus_cycle_start && modified_hit_indication_n;
  endproperty
  a_no_bus: assert property (p_no_bus) else $error("bus activity in self test");
  property p_float_off;
    float_mode |-> !pin_drive_enable && !bus_cycle_start;
  endproperty
  a_float_off: assert property (p_float_off) else $error("pins driven in float");
  property p_float_hold;
    float_mode && !sys_reset && !$past(sys_reset) && !$past(sys_reset, 2) && !$past(sys_reset, 3) |=> float_mode;
  endproperty
  a_float_hold: assert property (p_float_hold) else $error("float left early");
  property p_fan_quiet;
    float_mode && !fan_slow_event |=> !fan_slow_event;
  endproperty
  a_fan_quiet: assert property (p_fan_quiet) else $error("fan seen in float");
  property p_duration;
    self_test_done |-> busy_cnt_r >= BIST_CYCLES - 4 && busy_cnt_r <= BIST_CYCLES + 4;
  endproperty
  a_duration: assert property (p_duration) else $error("self test length off");
  property p_result_hold;
    core_running && $past(core_running) |-> $stable(accumulator_result_register);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed");
  property p_fan_set;
    (fan_too_slow && !float_mode)[*5] |-> fan_slow_event;
  endproperty
  a_fan_set: assert property (p_fan_set) else $error("fan event missed");
  property p_fan_sticky;
    fan_slow_event && !fan_event_clear |=> fan_slow_event;
  endproperty
  a_fan_sticky: assert property (p_fan_sticky) else $error("fan event lost");
endmodule
bind self_test_ctrl self_test_checker #(.BIST_CYCLES(BIST_CYCLES)) chk_i (.clk(clk), .reset_n(reset_n),
  .sys_reset(sys_reset), .address_hold_strap(address_hold_strap), .cache_flush_n(cache_flush_n),
  .fan_too_slow(fan_too_slow), .fan_event_clear(fan_event_clear), .bus_cycle_start(bus_cycle_start),
  .pin_drive_enable(pin_drive_enable), .modified_hit_indication_n(modified_hit_indication_n),
  .self_test_busy(self_test_busy), .self_test_done(self_test_done), .float_mode(float_mode),
  .core_running(core_running), .fan_slow_event(fan_slow_event),
  .accumulator_result_register(accumulator_result_register));

// ### testbench/testbench.sv
// self-checking bench for strap decode, self test and float mode
`timescale 1ns/1ps
`include "self_test_map_map.vh"
module testbench;
  localparam integer BIST_SIM = 512;
  reg clk;
  reg reset_n = 1'b0;
  reg external_snoop_strobe_n = 1'b1;
  reg fan_too_slow = 1'b0;
  reg stuck_fault_inject = 1'b0;
  reg core_bus_request = 1'b0;
  reg snoop_tag_hit = 1'b0;
  reg fan_event_clear = 1'b0;
  wire sys_reset, address_hold_strap, cache_flush_n;
  wire bus_cycle_start, pin_drive_enable, modified_hit_indication_n, self_test_busy;
  wire self_test_done, float_mode, core_running, fan_slow_event;
  wire [31:0] accumulator_result_register;
  integer fail_count = 0;
  integer samples_checked = 0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  board_reset_model board (.clk, .sys_reset, .address_hold_strap, .cache_flush_n);
  self_test_ctrl #(.BIST_CYCLES(BIST_SIM)) dut (.clk, .reset_n, .sys_reset, .address_hold_strap,
    .cache_flush_n, .external_snoop_strobe_n, .fan_too_slow, .stuck_fault_inject, .core_bus_request,
    .snoop_tag_hit, .fan_event_clear, .bus_cycle_start, .pin_drive_enable, .modified_hit_indication_n,
    .self_test_busy, .self_test_done, .float_mode, .core_running, .fan_slow_event,
    .accumulator_result_register);
  // ==========
  // shared helpers
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        fail_count++;
        $display("wrong value %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  function automatic logic seen(input integer sel);
    case (sel)
      0: seen = core_running;
      1: seen = self_test_busy;
      3: seen = float_mode;
      default: seen = !modified_hit_indication_n;
    endcase
  endfunction
  task wait_until(input integer sel, input integer lim);
    integer k;
    begin
      k = 0;
      while (seen(sel) !== 1'b1 && k < lim)
      begin
        @(negedge clk);
        k++;
      end
      samples_checked++;
      if (seen(sel) !== 1'b1)
      begin
        fail_count++;
        $display("wrong value wait %0d expected 1 seen 0", sel);
        report_and_stop;
      end
    end
  endtask
  // ==========
  // scenarios
  task test_plain;
    begin
      board.pulse_reset(1'b0, 1'b0);
      wait_until(0, 8);
      check("result", `RESULT_PASS, accumulator_result_register);
      check("busy", 0, self_test_busy);
      core_bus_request = 1'b1;
      repeat (2) @(negedge clk);
      check("bus start", 1, bus_cycle_start);
      core_bus_request = 1'b0;
      snoop_tag_hit = 1'b1;
      external_snoop_strobe_n = 1'b0;
      wait_until(4, 6);
      external_snoop_strobe_n = 1'b1;
      snoop_tag_hit = 1'b0;
      $display("plain reset test done");
    end
  endtask
  task run_bist(input logic fault, input logic [31:0] exp);
    integer k;
    begin
      stuck_fault_inject = fault;
      core_bus_request = 1'b1;
      external_snoop_strobe_n = 1'b1;
      board.pulse_reset(1'b1, 1'b0);
      wait_until(1, 8);
      k = 0;
      while (self_test_busy === 1'b1 && k < 600)
      begin
        check("bus start in test", 0, bus_cycle_start);
        @(negedge clk);
        k++;
      end
      check("done", 1, self_test_done);
      check("long test", 1, k >= BIST_SIM - 8);
      check("result", exp, accumulator_result_register);
      check("running", 1, core_running);
      core_bus_request = 1'b0;
      stuck_fault_inject = 1'b0;
      $display("self test run done");
    end
  endtask
  task test_float;
    integer k;
    begin
      fan_event_clear = 1'b1;
      @(negedge clk);
      fan_event_clear = 1'b0;
      board.pulse_reset(1'b1, 1'b1);
      wait_until(3, 8);
      check("pins driven", 0, pin_drive_enable);
      check("busy in float", 0, self_test_busy);
      fan_too_slow = 1'b1;
      core_bus_request = 1'b1;
      snoop_tag_hit = 1'b1;
      external_snoop_strobe_n = 1'b0;
      for (k = 0; k < 20; k++)
      begin
        @(negedge clk);
        check("float held", 1, float_mode);
      end
      check("bus in float", 0, bus_cycle_start);
      check("hit in float", 1, modified_hit_indication_n);
      check("fan in float", 0, fan_slow_event);
      fan_too_slow = 1'b0;
      core_bus_request = 1'b0;
      snoop_tag_hit = 1'b0;
      external_snoop_strobe_n = 1'b1;
      board.pulse_reset(1'b0, 1'b0);
      wait_until(0, 8);
      check("pins after float", 1, pin_drive_enable);
      $display("float mode test done");
    end
  endtask
  task test_fan;
    begin
      fan_too_slow = 1'b1;
      repeat (5) @(negedge clk);
      fan_too_slow = 1'b0;
      repeat (4) @(negedge clk);
      check("fan event", 1, fan_slow_event);
      fan_event_clear = 1'b1;
      @(negedge clk);
      fan_event_clear = 1'b0;
      check("fan cleared", 0, fan_slow_event);
      $display("fan event test done");
    end
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    test_plain;
    run_bist(1'b0, `RESULT_PASS);
    run_bist(1'b1, 32'hF << `RES_ARRAY_LSB);
    test_float;
    test_fan;
    report_and_stop;
  end
endmodule
